// *** hw/drg_channel.sv ***
// one channel of enhancer / compressor gain processing
`timescale 1ns/1ps
`default_nettype none
module drg_channel
  import drg_pkg::*;
#(
  parameter int W = 24
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire drg_mode_e    mode,
  input  wire drg_cfg_s     cfg,
  input  wire logic [W-1:0] sample_in,
  input  wire logic         sample_valid,
  output logic [W-1:0]      sample_out,
  output logic              out_valid,
  output logic [3:0]        front_gain
);
  localparam int LW = $clog2(W) + 1;

  // elaboration check on sample width
  if (W < 16 || W > 32)
  begin : g_bad_w
    $error("drg_channel: W must be 16..32");
  end

  // ==========================================================
  // level estimate
  function automatic logic [LW-1:0] lead_cnt(input logic [W-1:0] x);
    logic [LW-1:0] c;
    logic          done;
    c    = '0;
    done = 1'b0;
    for (int i = W - 2; i >= 0; i--)
    begin
      if (!done && x[i] == x[W-1])
        c = c + 1'b1;
      else
        done = 1'b1;
    end
    return c;
  endfunction

  logic [3:0]    thr_eff;
  logic [3:0]    max_eff;
  logic [LW-1:0] level;
  logic [LW-1:0] thr_bits;
  logic [LW-1:0] kmax;
  logic [LW-1:0] room;
  logic [LW-1:0] k;
  logic          below;
  logic [3:0]    cap;
  logic [W-1:0]  lim;
  logic [3:0]    front_gain_reg;
  logic [W-1:0]  sample_out_reg;
  logic          out_valid_reg;

  always_comb
  begin
    // shared codes, both modes
    // reserved codes clamp to the nearest legal code
    thr_eff  = (cfg.thr_code > THR_CODE_TOP) ? THR_CODE_TOP : cfg.thr_code;
    max_eff  = (cfg.max_code > MAX_CODE_TOP) ? MAX_CODE_TOP : cfg.max_code;
    level    = lead_cnt(sample_in);
    thr_bits = LW'(thr_eff) + LW'(THR_BASE_BITS);
    below    = level > thr_bits;
    cap      = max_eff + 4'h1;
    kmax     = LW'((int'(cap) * DB_PER_STEP) / DB_PER_BIT);
    room     = below ? level - thr_bits : '0;
    k        = (room < kmax) ? room : kmax;
    lim      = {1'b0, {(W-1){1'b1}}} >> thr_bits;
  end

  // ==========================================================
  // front stage gain tracking
  // enhancer gain steps
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      front_gain_reg <= 4'h0;
    else if (mode != MODE_ENH)
      front_gain_reg <= 4'h0;
    else if (front_gain_reg > cap)
      front_gain_reg <= front_gain_reg - 4'h1;
    else if (sample_valid && below && front_gain_reg < cap)
      front_gain_reg <= front_gain_reg + 4'h1;
    else if (sample_valid && !below && front_gain_reg != 4'h0)
      front_gain_reg <= front_gain_reg - 4'h1;
  end

  // ==========================================================
  // sample path, one cycle latency
  // compressor boost and limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sample_out_reg <= '0;
    else if (sample_valid && mode == MODE_CMP && below)
      sample_out_reg <= sample_in <<< k;
    else if (sample_valid && mode == MODE_CMP && level < thr_bits)
      sample_out_reg <= sample_in[W-1] ? ~lim : lim;
    else if (sample_valid)
      sample_out_reg <= sample_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_valid_reg <= 1'b0;
    else
      out_valid_reg <= sample_valid;
  end

  assign sample_out = sample_out_reg;
  assign out_valid  = out_valid_reg;
  assign front_gain = front_gain_reg;

  // ==========================================================
  // checks
  gain_step_up_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode == MODE_ENH && sample_valid && below && front_gain_reg < cap
    ##0 $stable(mode)
    |=> front_gain_reg == $past(front_gain_reg) + 4'h1)
    else $error("enhancer gain did not step up");

  gain_cap_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode == MODE_ENH && $stable(cfg) && front_gain_reg <= cap
    |=> front_gain_reg <= $past(cap))
    else $error("enhancer gain beyond cap");

  off_gain_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode != MODE_ENH |=> front_gain_reg == 4'h0)
    else $error("front gain moved outside enhancer mode");

  cmp_boost_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode == MODE_CMP && sample_valid && below
    |=> sample_out_reg == ($past(sample_in) <<< $past(k)) && out_valid_reg)
    else $error("compressor boost wrong");

  cmp_limit_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode == MODE_CMP && sample_valid && level < thr_bits && !sample_in[W-1]
    |=> sample_out_reg == $past(lim))
    else $error("compressor limit wrong");

  enh_ramp_c: cover property (
    @(posedge clk) disable iff (!rst_n)
    mode == MODE_ENH && front_gain_reg == cap);
endmodule
`default_nettype wire

// *** hw/drg_pkg.sv ***
// package: constants and types for dynamic range gain control
package drg_pkg;

  // register offsets, page 0
  localparam logic [7:0] OFS_CH1_CFG = 8'h3C;
  localparam logic [7:0] OFS_CH2_CFG = 8'h41;
  localparam logic [7:0] OFS_MODE    = 8'h6C;
  localparam logic [7:0] OFS_THR_MAX = 8'h6D;

  // field positions
  localparam int POS_CH_ON    = 0;
  localparam int POS_CMP_MODE = 1;
  localparam int POS_THR_LSB  = 4;
  localparam int POS_MAX_LSB  = 0;

  // reset values
  localparam logic [3:0] RST_THR_CODE = 4'h7;
  localparam logic [3:0] RST_MAX_CODE = 4'hB;
  localparam logic       RST_CH_ON    = 1'b0;
  localparam logic       RST_CMP_MODE = 1'b0;

  // code limits and mapping
  localparam logic [3:0] THR_CODE_TOP = 4'h9;
  localparam logic [3:0] MAX_CODE_TOP = 4'hE;
  localparam int         THR_BASE_BITS = 2;
  localparam int         DB_PER_BIT    = 6;
  localparam int         DB_PER_STEP   = 2;
  localparam int         NUM_CH        = 2;

  typedef struct packed {
    logic [3:0] thr_code;
    logic [3:0] max_code;
  } drg_cfg_s;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b001,
    MODE_ENH = 3'b010,
    MODE_CMP = 3'b100
  } drg_mode_e;

endpackage

// *** hw/drg_top.sv ***
// top: configuration registers and two gain channels
//
// Function
// - enhancer tracks input amplitude and moves channel front stage gain
// - threshold code 0 is -12 dB, each step 6 dB lower, 9 is -66 dB
// - threshold code resets to 7, which is -54 dB
// - max gain code 0 is 2 dB, each step adds 2 dB, 14 is 30 dB
// - max gain code resets to 11, which is 24 dB
// - each channel has its own enable bit in its own register
// - compressor boosts low signals and limits output amplitude, low latency
// - compressor reuses the shared threshold and max gain encodings
// - mode bit set selects compressor; channel enables still pick channels
`timescale 1ns/1ps
`default_nettype none
module drg_top
  import drg_pkg::*;
#(
  parameter int W = 24
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    reg_wr_en,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wr_data,
  output logic [7:0]                   reg_rd_data,
  input  wire logic [NUM_CH-1:0][W-1:0] samp_in,
  input  wire logic [NUM_CH-1:0]       samp_valid,
  output logic [NUM_CH-1:0][W-1:0]     samp_out,
  output logic [NUM_CH-1:0]            samp_out_valid,
  output logic [NUM_CH-1:0][3:0]       front_gain
);

  // elaboration check on sample width
  if (W < 16 || W > 32)
  begin : g_bad_w
    $error("drg_top: W must be 16..32");
  end

  // ==========================================================
  // configuration registers
  drg_cfg_s          cfg_reg;
  logic [NUM_CH-1:0] ch_on_reg;
  logic              cmp_mode_reg;
  logic [7:0]        rd_data_reg;
  logic [7:0]        rd_data_next;
  logic              first_reg;
  drg_mode_e         ch_mode [NUM_CH];

  // shared threshold and max gain
  // threshold reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg.thr_code <= RST_THR_CODE;
      cfg_reg.max_code <= RST_MAX_CODE;
    end
    else if (reg_wr_en && reg_addr == OFS_THR_MAX)
    begin
      cfg_reg.thr_code <= reg_wr_data[POS_THR_LSB +: 4];
      cfg_reg.max_code <= reg_wr_data[POS_MAX_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ch_on_reg <= {NUM_CH{RST_CH_ON}};
    else if (reg_wr_en && reg_addr == OFS_CH1_CFG)
      ch_on_reg[0] <= reg_wr_data[POS_CH_ON];
    else if (reg_wr_en && reg_addr == OFS_CH2_CFG)
      ch_on_reg[1] <= reg_wr_data[POS_CH_ON];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmp_mode_reg <= RST_CMP_MODE;
    else if (reg_wr_en && reg_addr == OFS_MODE)
      cmp_mode_reg <= reg_wr_data[POS_CMP_MODE];
  end

  // ==========================================================
  // read back, unmapped offsets read zero
  always_comb
  begin
    rd_data_next = 8'h00;
    case (reg_addr)
      OFS_CH1_CFG: rd_data_next[POS_CH_ON]    = ch_on_reg[0];
      OFS_CH2_CFG: rd_data_next[POS_CH_ON]    = ch_on_reg[1];
      OFS_MODE:    rd_data_next[POS_CMP_MODE] = cmp_mode_reg;
      OFS_THR_MAX: rd_data_next = {cfg_reg.thr_code, cfg_reg.max_code};
      default:     rd_data_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_reg <= 8'h00;
    else
      rd_data_reg <= rd_data_next;
  end

  assign reg_rd_data = rd_data_reg;

  // marks the first cycle after reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      first_reg <= 1'b0;
    else
      first_reg <= 1'b1;
  end

  // ==========================================================
  // channel mode select and channels
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      // enabled channel without mode bit runs enhancer
      always_comb
      begin
        if (!ch_on_reg[g])
          ch_mode[g] = MODE_OFF;
        else if (cmp_mode_reg)
          ch_mode[g] = MODE_CMP;
        else
          ch_mode[g] = MODE_ENH;
      end

      drg_channel #(
        .W (W)
      ) u_ch (
        .clk          (clk),
        .rst_n        (rst_n),
        .mode         (ch_mode[g]),
        .cfg          (cfg_reg),
        .sample_in    (samp_in[g]),
        .sample_valid (samp_valid[g]),
        .sample_out   (samp_out[g]),
        .out_valid    (samp_out_valid[g]),
        .front_gain   (front_gain[g])
      );
    end
  endgenerate

  // ==========================================================
  // checks
  cfg_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !first_reg |-> cfg_reg.thr_code == 4'h7 && cfg_reg.max_code == 4'hB)
    else $error("threshold or max gain reset value wrong");

  rd_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !first_reg && !$past(reg_wr_en) && reg_addr == OFS_THR_MAX
    |=> reg_rd_data == 8'h7B)
    else $error("reset readback of shared register wrong");

  cfg_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && reg_addr == OFS_THR_MAX
    |=> {cfg_reg.thr_code, cfg_reg.max_code} == $past(reg_wr_data))
    else $error("shared register write lost");

  ch2_enable_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && reg_addr == OFS_CH2_CFG
    |=> ch_on_reg[1] == $past(reg_wr_data[0]) && $stable(ch_on_reg[0]))
    else $error("channel 2 enable write wrong");

  cmp_select_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && reg_addr == OFS_MODE && reg_wr_data[1] && ch_on_reg[0]
    ##1 ch_on_reg[0] |-> ch_mode[0] == MODE_CMP)
    else $error("compressor mode not selected");

  enh_select_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ch_on_reg[1] && !cmp_mode_reg |-> ch_mode[1] == MODE_ENH)
    else $error("enhancer mode not selected");

  cmp_run_c: cover property (
    @(posedge clk) disable iff (!rst_n)
    ch_mode[0] == MODE_CMP && samp_valid[0]);

  both_on_c: cover property (
    @(posedge clk) disable iff (!rst_n)
    ch_mode[0] == MODE_ENH && ch_mode[1] == MODE_ENH);

  ch1_enable_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && reg_addr == OFS_CH1_CFG
    |=> ch_on_reg[0] == $past(reg_wr_data[0]) && $stable(ch_on_reg[1]))
    else $error("channel 1 enable write wrong");

  mode_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && reg_addr == OFS_MODE
    |=> cmp_mode_reg == $past(reg_wr_data[POS_CMP_MODE]))
    else $error("compressor mode bit write lost");

  off_select_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ch_on_reg[0] |-> ch_mode[0] == MODE_OFF)
    else $error("disabled channel not off");

  ch2_run_c: cover property (
    @(posedge clk) disable iff (!rst_n)
    ch_mode[1] == MODE_ENH && samp_valid[1]);

endmodule
`default_nettype wire

// *** tb/drg_top_bench.sv ***
// testbench: register access and gain paths of drg_top
`timescale 1ns/1ps
`default_nettype none
module drg_top_bench
  import drg_pkg::*;
;
  // ==========================================
  // signals
  localparam int W = 24;
  logic                     clk;
  logic                     rst_n;
  logic                     reg_wr_en;
  logic [7:0]               reg_addr;
  logic [7:0]               reg_wr_data;
  logic [7:0]               reg_rd_data;
  logic [NUM_CH-1:0][W-1:0] samp_in;
  logic [NUM_CH-1:0]        samp_valid;
  logic [NUM_CH-1:0][W-1:0] samp_out;
  logic [NUM_CH-1:0]        samp_out_valid;
  logic [NUM_CH-1:0][3:0]   front_gain;
  int                       n_mismatch;
  int                       n_tests;
  // compressor cases: config byte, input, expected output
  // no reserved codes; last row keeps advice
  logic [7:0]   cfg_tab [7] = '{8'h02, 8'h02, 8'h02, 8'h02,
                                8'h0E, 8'h9E, 8'h4A};
  logic [W-1:0] in_tab  [7] = '{24'h000010, 24'h7FFFFF, 24'h800000,
                                24'h100000, 24'h000001, 24'h7FFFFF,
                                24'h000001};
  logic [W-1:0] out_tab [7] = '{24'h000020, 24'h1FFFFF, 24'hE00000,
                                24'h100000, 24'h000020, 24'h000FFF,
                                24'h000008};

  // ==========================================
  // design and clock
  drg_top #(.W(W)) DUT
  (
    .clk            (clk),
    .rst_n          (rst_n),
    .reg_wr_en      (reg_wr_en),
    .reg_addr       (reg_addr),
    .reg_wr_data    (reg_wr_data),
    .reg_rd_data    (reg_rd_data),
    .samp_in        (samp_in),
    .samp_valid     (samp_valid),
    .samp_out       (samp_out),
    .samp_out_valid (samp_out_valid),
    .front_gain     (front_gain)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr_en   = 1'b1;
    reg_addr    = a;
    reg_wr_data = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    chk("reg_rd_data", {24'h0, reg_rd_data}, {24'h0, exp});
  endtask

  task automatic smp(input int ch, input logic [W-1:0] d,
                     input logic [W-1:0] eo, input logic [3:0] eg);
    @(negedge clk);
    chk("samp_out_valid", {31'h0, samp_out_valid[ch]}, 32'h0);
    samp_in[ch]    = d;
    samp_valid[ch] = 1'b1;
    @(negedge clk);
    samp_valid[ch] = 1'b0;
    chk("samp_out_valid", {31'h0, samp_out_valid[ch]}, 32'h1);
    chk("samp_out", {8'h0, samp_out[ch]}, {8'h0, eo});
    chk("front_gain", {28'h0, front_gain[ch]}, {28'h0, eg});
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  // ==========================================
  // main sequence
  initial
  begin
    n_mismatch  = 0;
    n_tests     = 0;
    rst_n       = 1'b0;
    reg_wr_en   = 1'b0;
    reg_addr    = OFS_THR_MAX;
    reg_wr_data = 8'h00;
    // samples stand for an ac-coupled mic at legal rate
    samp_in     = '0;
    samp_valid  = '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    rd(OFS_THR_MAX, 8'h7B);
    rd(OFS_CH1_CFG, 8'h00);
    rd(OFS_CH2_CFG, 8'h00);
    rd(OFS_MODE, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset_values done");
    // set up with samples idle, one function only
    wr(OFS_THR_MAX, 8'h9E);
    rd(OFS_THR_MAX, 8'h9E);
    wr(OFS_CH1_CFG, 8'hFF);
    rd(OFS_CH1_CFG, 8'h01);
    wr(OFS_MODE, 8'hFF);
    rd(OFS_MODE, 8'h02);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h00);
    $display("test register_access done");
    for (int i = 0; i < 7; i++)
    begin
      wr(OFS_THR_MAX, cfg_tab[i]);
      smp(0, in_tab[i], out_tab[i], 4'h0);
    end
    smp(1, 24'h000010, 24'h000010, 4'h0);
    $display("test compressor done");
    wr(OFS_MODE, 8'h00);
    wr(OFS_THR_MAX, 8'h00);
    smp(0, 24'h080000, 24'h080000, 4'h1);
    smp(0, 24'h100000, 24'h100000, 4'h0);
    smp(0, 24'h000001, 24'h000001, 4'h1);
    smp(0, 24'h000001, 24'h000001, 4'h1);
    smp(0, 24'h400000, 24'h400000, 4'h0);
    wr(OFS_THR_MAX, 8'h01);
    smp(0, 24'h000001, 24'h000001, 4'h1);
    smp(0, 24'h000001, 24'h000001, 4'h2);
    smp(0, 24'h000001, 24'h000001, 4'h2);
    smp(1, 24'h000001, 24'h000001, 4'h0);
    wr(OFS_CH2_CFG, 8'h01);
    rd(OFS_CH2_CFG, 8'h01);
    smp(1, 24'h000001, 24'h000001, 4'h1);
    wr(OFS_THR_MAX, 8'h00);
    smp(0, 24'h000001, 24'h000001, 4'h1);
    $display("test enhancer done");
    wr(OFS_CH1_CFG, 8'h00);
    smp(0, 24'h000001, 24'h000001, 4'h0);
    $display("test channel_off done");
    @(negedge clk);
    reg_addr = OFS_THR_MAX;
    rst_n    = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(OFS_THR_MAX, 8'h7B);
    smp(1, 24'h000001, 24'h000001, 4'h0);
    $display("test mid_reset done");
    end_sim();
  end
endmodule
`default_nettype wire
